// [include/sef_consts.svh]
// Constants for the serial EEPROM front end: opcodes, status layout, timing
`ifndef SEF_CONSTS_SVH
`define SEF_CONSTS_SVH

`define SEF_OP_SET_WEL 8'h06
`define SEF_OP_CLR_WEL 8'h04
`define SEF_OP_WR_STAT 8'h01
`define SEF_OP_RD_STAT 8'h05

`define SEF_ST_BUSY_BIT 0
`define SEF_ST_WEL_BIT 1
`define SEF_ST_BP_LO_BIT 2
`define SEF_ST_BP_HI_BIT 3
`define SEF_ST_PPA_BIT 6
`define SEF_ST_PROTECT_PIN_ENABLE_BIT 7
`define SEF_ST_UNUSED 2'h3
`define SEF_ST_BUSY_READ 8'hFF

`define SEF_MEM_BYTES 1024
`define SEF_PAGE_BYTES 32
`define SEF_PAGE_W 5
`define SEF_ADDR_W 10
`define SEF_PAGE_QUARTER 5'h18
`define SEF_PAGE_HALF 5'h10
`define SEF_PAGE_ALL 5'h00

`define SEF_CLK_MHZ 50
`define SEF_WRITE_TIME_US 5000
`define SEF_BUSY_W 24

`endif

// [include/sef_pkg.sv]
// Types shared by the serial EEPROM front end
`include "sef_consts.svh"

package sef_pkg;

  typedef enum logic [2:0] {
    SEF_IDLE = 3'b000,
    SEF_CMD = 3'b001,
    SEF_LATCH = 3'b010,
    SEF_WRDATA = 3'b011,
    SEF_WRDONE = 3'b100,
    SEF_RDOUT = 3'b101,
    SEF_IGNORE = 3'b110
  } sef_state_e;

  typedef struct packed {
    sef_state_e state;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] outsh;
    logic out_live;
    logic paused;
    logic write_enable_latch;
    logic [1:0] bp;
    logic protect_pin_enable;
    logic page_protect_ack;
    logic [`SEF_BUSY_W-1:0] busy_cnt;
    logic busy;
    logic so;
    logic so_oe;
    logic prot_any;
    logic [`SEF_ADDR_W-1:0] prot_base;
  } sef_core_s;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
  } sef_sync_s;

endpackage

// [include/sef_pin_if.sv]
// Synchronised pin levels and edges passed from the pin stage to the core
`timescale 1ns/1ps

interface sef_pin_if;
  logic sck;
  logic si;
  logic cs_n;
  logic hold_n;
  logic wp_n;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  modport sync (output sck, si, cs_n, hold_n, wp_n, sck_rise, sck_fall, cs_fall, cs_rise);
  modport core (input sck, si, cs_n, hold_n, wp_n, sck_rise, sck_fall, cs_fall, cs_rise);
endinterface

// [src/sef_pin_sync.sv]
// Two-stage synchronisers and edge detection for the serial pins
`timescale 1ns/1ps

module sef_pin_sync (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  sef_pin_if.sync pins
);

  sef_pkg::sef_sync_s st;
  sef_pkg::sef_sync_s nx;

  // Bit order: {sck, si, cs_n, hold_n, wp_n}
  always_comb begin
    nx = st;
    nx.s1 = {sck_in, si_in, cs_n_in, hold_n_in, wp_n_in};
    nx.s2 = st.s1;
    nx.s3 = st.s2;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= {3{5'h0F}};
    end else begin
      st <= nx;
    end
  end

  assign pins.sck = st.s2[4];
  assign pins.si = st.s2[3];
  assign pins.cs_n = st.s2[2];
  assign pins.hold_n = st.s2[1];
  assign pins.wp_n = st.s2[0];
  assign pins.sck_rise = st.s2[4] & ~st.s3[4];
  assign pins.sck_fall = ~st.s2[4] & st.s3[4];
  assign pins.cs_fall = ~st.s2[2] & st.s3[2];
  assign pins.cs_rise = st.s2[2] & ~st.s3[2];

endmodule

// [src/sef_spi_front.sv]
// Serial slave front end and status register of a 1024-byte serial EEPROM
// Operation
// - While paused, ignore data input and keep data output high impedance.
// - While paused, clock toggles shift nothing and advance no state.
// - After a pause the interrupted command continues where it stopped.
// - Storage is 32 pages of 32 bytes; one page programs at once.
// - Device responds only while its active-low select is asserted.
// - Sample input on clock rise, change output on clock fall.
// - Every byte travels most significant bit first.
// - Unknown command: ignore input, output off until next select fall.
// - All status bits readable; status write changes only protect and pin-enable.
// - Latch bit set only by set latch command; cleared by clear latch command or by an accepted status write.
// - Status or memory writes refused while write latch is clear.
// - Bit 0 reads 1 during programming, 0 when ready; not writable.
// - Bits 2 and 3 hold the readable, writable block-protect setting.
// - Bits 4 and 5 always read as 1.
// - Bit 6 is 1 without page protection; else page-protect acknowledge.
// - Bit 7 enables the write-protect pin; 0 ignores the pin.
// - Opcodes 06 set, 04 clear, 01 write, 05 read; latch commands alone.
// - Status read accepted anytime, even during programming.
// - Protect 00 none, 01 300-3FF, 10 200-3FF, 11 whole array.
// - During programming every status bit reads as 1.
`timescale 1ns/1ps
`include "sef_consts.svh"

module sef_spi_front #(
  parameter int WRITE_CYCLE_CLKS = `SEF_WRITE_TIME_US * `SEF_CLK_MHZ,
  parameter bit PAGE_PROTECT = 1'b0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  input wire logic pp_start_in,
  input wire logic pp_ok_in,
  output logic so_out,
  output logic so_oe_out,
  output logic programming_active_out,
  output logic write_enable_latch_out,
  output logic [1:0] block_protect_out,
  output logic protect_any_out,
  output logic [`SEF_ADDR_W-1:0] protect_base_out
);

  sef_pin_if pins ();

  sef_pin_sync u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sck_in(sck_in),
    .si_in(si_in),
    .cs_n_in(cs_n_in),
    .hold_n_in(hold_n_in),
    .wp_n_in(wp_n_in),
    .pins(pins)
  );

  localparam sef_pkg::sef_core_s RESET_ST = '{
    state: sef_pkg::SEF_IDLE,
    bitcnt: 3'h0,
    shift: 8'h00,
    outsh: 8'h00,
    out_live: 1'b0,
    paused: 1'b0,
    write_enable_latch: 1'b0,
    bp: 2'h0,
    protect_pin_enable: 1'b0,
    page_protect_ack: 1'b1,
    busy_cnt: '0,
    busy: 1'b0,
    so: 1'b0,
    so_oe: 1'b0,
    prot_any: 1'b0,
    prot_base: '0
  };

  sef_pkg::sef_core_s st;
  sef_pkg::sef_core_s nx;
  logic [7:0] status_now;
  logic [7:0] cmd_byte;
  logic wr_allowed;
  logic [`SEF_PAGE_W-1:0] base_page;

  always_comb begin
    if (st.busy) begin
      status_now = `SEF_ST_BUSY_READ;
    end else begin
      status_now = {st.protect_pin_enable, PAGE_PROTECT ? st.page_protect_ack : 1'b1,
                    `SEF_ST_UNUSED, st.bp, st.write_enable_latch, 1'b0};
    end
  end

  assign cmd_byte = {st.shift[6:0], pins.si};
  assign wr_allowed = st.write_enable_latch && !(st.protect_pin_enable && !pins.wp_n);

  always_comb begin
    nx = st;
    nx.so_oe = 1'b0;
    if (st.busy_cnt != '0) begin
      nx.busy_cnt = st.busy_cnt - 1'b1;
    end
    if (pp_start_in) begin
      nx.page_protect_ack = 1'b1;
    end else if (pp_ok_in) begin
      nx.page_protect_ack = 1'b0;
    end
    if (pins.cs_fall) begin
      // Fresh frame, also recovers from an ignored command
      nx.state = sef_pkg::SEF_CMD;
      nx.bitcnt = 3'h0;
      nx.paused = 1'b0;
      nx.out_live = 1'b0;
    end else if (pins.cs_rise) begin
      if (st.state == sef_pkg::SEF_LATCH) begin
        nx.write_enable_latch = (st.shift == `SEF_OP_SET_WEL);
      end else if (st.state == sef_pkg::SEF_WRDONE && wr_allowed) begin
        nx.bp = {st.shift[`SEF_ST_BP_HI_BIT], st.shift[`SEF_ST_BP_LO_BIT]};
        nx.protect_pin_enable = st.shift[`SEF_ST_PROTECT_PIN_ENABLE_BIT];
        nx.write_enable_latch = 1'b0;
        nx.busy_cnt = `SEF_BUSY_W'(WRITE_CYCLE_CLKS);
      end
      nx.state = sef_pkg::SEF_IDLE;
      nx.paused = 1'b0;
    end else if (!pins.cs_n && st.state != sef_pkg::SEF_IDLE) begin
      if (!pins.sck) begin
        nx.paused = !pins.hold_n;
      end
      if (!st.paused) begin
        if (pins.sck_rise) begin
          nx.shift = cmd_byte;
          nx.bitcnt = st.bitcnt + 3'h1;
          case (st.state)
            sef_pkg::SEF_CMD: begin
              if (st.bitcnt == 3'h7) begin
                nx.bitcnt = 3'h0;
                if (cmd_byte == `SEF_OP_RD_STAT) begin
                  nx.state = sef_pkg::SEF_RDOUT;
                  nx.outsh = status_now;
                end else if (st.busy) begin
                  nx.state = sef_pkg::SEF_IGNORE;
                end else if (cmd_byte == `SEF_OP_SET_WEL || cmd_byte == `SEF_OP_CLR_WEL) begin
                  nx.state = sef_pkg::SEF_LATCH;
                end else if (cmd_byte == `SEF_OP_WR_STAT) begin
                  nx.state = sef_pkg::SEF_WRDATA;
                end else begin
                  nx.state = sef_pkg::SEF_IGNORE;
                end
              end
            end
            sef_pkg::SEF_WRDATA: begin
              if (st.bitcnt == 3'h7) begin
                nx.state = sef_pkg::SEF_WRDONE;
              end
            end
            sef_pkg::SEF_RDOUT: begin
              nx.shift = st.shift;
              if (st.bitcnt == 3'h7) begin
                nx.outsh = status_now;
              end
            end
            sef_pkg::SEF_LATCH, sef_pkg::SEF_WRDONE: begin
              // Trailing bits spoil a latch or status write
              nx.state = sef_pkg::SEF_IGNORE;
              nx.shift = st.shift;
            end
            default: begin
              nx.shift = st.shift;
            end
          endcase
        end
        if (pins.sck_fall && st.state == sef_pkg::SEF_RDOUT) begin
          nx.so = st.outsh[7];
          nx.outsh = {st.outsh[6:0], 1'b0};
          nx.out_live = 1'b1;
        end
      end
    end
    nx.so_oe = (nx.state == sef_pkg::SEF_RDOUT) && nx.out_live && !nx.paused
               && !pins.cs_n;
    nx.busy = (nx.busy_cnt != '0);
    nx.prot_any = (nx.bp != 2'h0);
    nx.prot_base = {base_page, 5'h00};
  end

  always_comb begin
    case (st.bp)
      2'h1: base_page = `SEF_PAGE_QUARTER;
      2'h2: base_page = `SEF_PAGE_HALF;
      default: base_page = `SEF_PAGE_ALL;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= RESET_ST;
    end else begin
      st <= nx;
    end
  end

  assign so_out = st.so;
  assign so_oe_out = st.so_oe;
  assign programming_active_out = st.busy;
  assign write_enable_latch_out = st.write_enable_latch;
  assign block_protect_out = st.bp;
  assign protect_any_out = st.prot_any;
  assign protect_base_out = st.prot_base;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_oe_deselect: assert property (pins.cs_n |=> !so_oe_out)
    else $error("output enabled while deselected");

  chk_pause_hiz: assert property (st.paused |-> !so_oe_out)
    else $error("output enabled while paused");

  chk_pause_noshift: assert property (
    (st.paused && !pins.cs_n && !pins.cs_rise && pins.sck_rise)
    |=> $stable(st.bitcnt) && $stable(st.shift) && $stable(st.state))
    else $error("paused device advanced on clock");

  chk_wel_cause: assert property ($rose(st.write_enable_latch)
    |-> $past(st.shift) == `SEF_OP_SET_WEL && $past(st.state) == sef_pkg::SEF_LATCH)
    else $error("latch set without set command");

  chk_busy_all_ones: assert property ((st.busy && so_oe_out) |-> so_out)
    else $error("status bit 0 seen while busy");

  chk_sr_needs_wel: assert property (
    (pins.cs_rise && st.state == sef_pkg::SEF_WRDONE && !st.write_enable_latch)
    |=> $stable(st.bp) && $stable(st.protect_pin_enable) && !st.busy)
    else $error("status write accepted without latch");

  chk_wp_blocks: assert property (
    (pins.cs_rise && st.state == sef_pkg::SEF_WRDONE && st.protect_pin_enable && !pins.wp_n)
    |=> $stable(st.bp) && st.protect_pin_enable)
    else $error("status write passed protect pin");

  chk_sr_commit: assert property (
    (pins.cs_rise && st.state == sef_pkg::SEF_WRDONE && wr_allowed)
    |=> !st.write_enable_latch && st.busy && st.bp == $past(st.shift[3:2]))
    else $error("status write did not commit");

  chk_invalid_quiet: assert property (
    (st.state == sef_pkg::SEF_IGNORE && !pins.cs_fall) |=> !so_oe_out)
    else $error("output driven after bad command");

  chk_busy_hold: assert property ($rose(st.busy) |-> st.busy [*8])
    else $error("busy dropped too early");

  // Bit accepted by the shifter on this cycle
  logic bit_take;

  assign bit_take = pins.sck_rise && !pins.cs_n && !pins.cs_fall && !st.paused
                    && st.state != sef_pkg::SEF_IDLE;

  chk_shift_msb: assert property (
    (bit_take && (st.state == sef_pkg::SEF_CMD || st.state == sef_pkg::SEF_WRDATA))
    |=> st.shift == {$past(st.shift[6:0]), $past(pins.si)})
    else $error("serial input not shifted in msb first");

  chk_take_on_rise: assert property (
    (!pins.sck_rise && !pins.cs_fall) |=> $stable(st.bitcnt))
    else $error("input bit taken without a clock rise");

  chk_out_on_fall: assert property ($changed(so_out) |-> $past(pins.sck_fall))
    else $error("serial output changed off a clock fall");

  chk_status_read_cmd_any_time: assert property (
    (bit_take && st.state == sef_pkg::SEF_CMD && st.bitcnt == 3'h7
     && cmd_byte == `SEF_OP_RD_STAT) |=> st.state == sef_pkg::SEF_RDOUT)
    else $error("status read opcode not accepted");

  chk_busy_load_ones: assert property (
    (bit_take && st.state == sef_pkg::SEF_CMD && st.bitcnt == 3'h7 && st.busy
     && cmd_byte == `SEF_OP_RD_STAT) |=> st.outsh == `SEF_ST_BUSY_READ)
    else $error("busy status byte not all ones");

  chk_ready_load: assert property (
    (bit_take && st.state == sef_pkg::SEF_CMD && st.bitcnt == 3'h7 && !st.busy
     && cmd_byte == `SEF_OP_RD_STAT)
    |=> st.outsh[`SEF_ST_BUSY_BIT] == 1'b0 && st.outsh[5:4] == `SEF_ST_UNUSED)
    else $error("ready status byte has wrong fixed bits");

  chk_bad_opcode: assert property (
    (bit_take && st.state == sef_pkg::SEF_CMD && st.bitcnt == 3'h7
     && !(cmd_byte inside {`SEF_OP_SET_WEL, `SEF_OP_CLR_WEL,
                           `SEF_OP_WR_STAT, `SEF_OP_RD_STAT}))
    |=> st.state == sef_pkg::SEF_IGNORE)
    else $error("unknown opcode not ignored");

  chk_ppa_success: assert property ((pp_ok_in && !pp_start_in) |=> !st.page_protect_ack)
    else $error("page protect acknowledge not cleared");

  chk_ppa_start: assert property (pp_start_in |=> st.page_protect_ack)
    else $error("page protect acknowledge not set on start");

  chk_wel_fall_cause: assert property ($fell(st.write_enable_latch) |->
    ($past(st.state) == sef_pkg::SEF_LATCH && $past(st.shift) == `SEF_OP_CLR_WEL)
    || $past(st.state) == sef_pkg::SEF_WRDONE)
    else $error("latch cleared without clear command or write");

  chk_prot_by_write: assert property (
    ($changed(st.bp) || $changed(st.protect_pin_enable))
    |-> $past(pins.cs_rise) && $past(st.state) == sef_pkg::SEF_WRDONE && $past(wr_allowed))
    else $error("protect bits changed outside a status write");

endmodule

// [verification/sef_spi_master_model.sv]
// SPI bus master model driving the serial front end
`timescale 1ns/1ps
module sef_spi_master_model (
  output logic sck_out,
  output logic si_out,
  output logic cs_n_out,
  output logic hold_n_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  logic cpol = 1'b0;
  logic last = 1'b0;
  logic oe_seen = 1'b0;
  initial begin
    sck_out = 1'b0;
    si_out = 1'b0;
    cs_n_out = 1'b1;
    hold_n_out = 1'b1;
  end
  always @(posedge so_oe_in) oe_seen = 1'b1;
  task automatic cs_lo(input logic m);
    cpol = m;
    sck_out = m;
    #160 cs_n_out = 1'b0;
    #160;
  endtask
  task automatic cs_hi();
    #80 cs_n_out = 1'b1;
    #240;
  endtask
  // Pause before bit hb with the clock low, garbage on data meanwhile
  task automatic xfer(input logic [7:0] tx, input int hb, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (cpol) sck_out = 1'b0;
      if (i == hb) begin
        hold_n_out = 1'b0;
        repeat (3) begin
          #80 sck_out = 1'b1;
          si_out = ~si_out;
          #80 sck_out = 1'b0;
        end
        #80 hold_n_out = 1'b1;
        #80;
      end
      si_out = tx[i];
      #80 sck_out = 1'b1;
      // Released line shows the inverse of the last bit
      #80 rx[i] = so_oe_in ? so_in : ~last;
      last = rx[i];
      if (!cpol) sck_out = 1'b0;
    end
  endtask
endmodule

// [verification/sef_spi_front_tb.sv]
// Self-checking bench for the serial front end and its status register
`timescale 1ns/1ps
module sef_spi_front_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sck, si, cs_n, hold_n, so_out, so_oe_out, busy, write_enable_latch, any;
  logic wp_n_in = 1'b1;
  logic pp_start_in = 1'b0;
  logic pp_ok_in = 1'b0;
  logic [1:0] bp;
  logic [9:0] base;
  logic [7:0] rx;
  int num_errors = 0;
  int n_compared = 0;
  sef_spi_front #(.WRITE_CYCLE_CLKS(200), .PAGE_PROTECT(1'b1)) i_dut (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sck_in(sck),
    .si_in(si),
    .cs_n_in(cs_n),
    .hold_n_in(hold_n),
    .wp_n_in(wp_n_in),
    .pp_start_in(pp_start_in),
    .pp_ok_in(pp_ok_in),
    .so_out(so_out),
    .so_oe_out(so_oe_out),
    .programming_active_out(busy),
    .write_enable_latch_out(write_enable_latch),
    .block_protect_out(bp),
    .protect_any_out(any),
    .protect_base_out(base)
  );
  sef_spi_master_model i_master (
    .sck_out(sck),
    .si_out(si),
    .cs_n_out(cs_n),
    .hold_n_out(hold_n),
    .so_in(so_out),
    .so_oe_in(so_oe_out)
  );
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    i_master.cs_lo(1'b0);
    i_master.xfer(op, -1, rx);
    i_master.cs_hi();
  endtask
  task automatic rd_stat(input logic m, input int hb, input logic [7:0] exp);
    i_master.cs_lo(m);
    i_master.xfer(8'h05, hb, rx);
    i_master.xfer(8'h00, hb, rx);
    i_master.cs_hi();
    chk("status", rx, exp);
  endtask
  task automatic wr_stat(input logic [7:0] d, input logic en, input logic m);
    if (en) cmd(8'h06);
    i_master.cs_lo(m);
    i_master.xfer(8'h01, -1, rx);
    i_master.xfer(d, -1, rx);
    i_master.cs_hi();
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 400 && busy !== 1'b0; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk("busy", busy, 1'b0);
  endtask
  task automatic t_reset();
    chk("oe", so_oe_out, 1'b0);
    chk("wel", write_enable_latch, 1'b0);
    rd_stat(1'b0, -1, 8'h70);
  endtask
  task automatic t_latch();
    cmd(8'h06);
    chk("wel", write_enable_latch, 1'b1);
    rd_stat(1'b1, -1, 8'h72);
    cmd(8'h04);
    chk("wel", write_enable_latch, 1'b0);
    wr_stat(8'h8C, 1'b0, 1'b0);
    chk("busy", busy, 1'b0);
    rd_stat(1'b0, -1, 8'h70);
  endtask
  task automatic t_protect();
    logic [7:0] d [4] = '{8'h77, 8'h7B, 8'h7F, 8'h73};
    logic [9:0] b [4] = '{10'h300, 10'h200, 10'h000, 10'h000};
    for (int i = 0; i < 4; i++) begin
      wr_stat(d[i], 1'b1, i[0]);
      chk("busy", busy, 1'b1);
      rd_stat(1'b0, -1, 8'hFF);
      wait_idle();
      chk("bp", bp, d[i][3:2]);
      chk("any", any, i < 3);
      chk("base", base, b[i]);
      rd_stat(1'b0, -1, {4'h7, d[i][3:2], 2'h0});
    end
  endtask
  task automatic t_protect_pin_enable();
    wr_stat(8'h80, 1'b1, 1'b0);
    wait_idle();
    wp_n_in = 1'b0;
    wr_stat(8'h0C, 1'b1, 1'b0);
    chk("busy", busy, 1'b0);
    chk("wel", write_enable_latch, 1'b1);
    rd_stat(1'b0, -1, 8'hF2);
    wp_n_in = 1'b1;
    wr_stat(8'h00, 1'b1, 1'b0);
    wait_idle();
    rd_stat(1'b0, -1, 8'h70);
  endtask
  task automatic t_invalid();
    i_master.oe_seen = 1'b0;
    i_master.cs_lo(1'b0);
    i_master.xfer(8'h03, -1, rx);
    i_master.xfer(8'h05, -1, rx);
    i_master.xfer(8'h00, -1, rx);
    i_master.cs_hi();
    i_master.xfer(8'h06, -1, rx);
    chk("oe", i_master.oe_seen, 1'b0);
    chk("wel", write_enable_latch, 1'b0);
    rd_stat(1'b0, 3, 8'h70);
  endtask
  task automatic pulse(input logic ok);
    @(posedge clk_in);
    #1 {pp_ok_in, pp_start_in} = {ok, ~ok};
    @(posedge clk_in);
    #1 {pp_ok_in, pp_start_in} = 2'b00;
  endtask
  task automatic t_pp();
    pulse(1'b1);
    rd_stat(1'b0, -1, 8'h30);
    pulse(1'b0);
    rd_stat(1'b0, -1, 8'h70);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    t_reset();
    t_latch();
    t_protect();
    t_protect_pin_enable();
    t_invalid();
    t_pp();
    end_of_test();
  end
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end
endmodule
